/* File: rtl/clock_startup_regs.svh */
`ifndef CLOCK_STARTUP_REGS_SVH
`define CLOCK_STARTUP_REGS_SVH

// Register offsets on the plain register port
`define TRIM_REG_OFS      8'h00
`define STATUS_REG_OFS    8'h01

// Status register field positions
`define STAT_STATE_LSB    0
`define STAT_RUN_BIT      3
`define STAT_DIV8_BIT     4
`define STAT_ERR_BIT      5
`define STAT_LF_BIT       6
`define STAT_RC_BIT       7

// Clock source select codes
`define CKSRC_LF_SHORT    4'h6
`define CKSRC_LF_LONG     4'h7
`define CKSRC_RC          4'h2

// Start-up time codes
`define DELAY_NONE        2'h0
`define DELAY_SHORT       2'h1
`define DELAY_LONG        2'h2
`define DELAY_RESERVED    2'h3

// Reset values
`define TRIM_RESET        7'h00
`define DIV8_RESET        1'b1

// Timing counts, in cycles of the clock that is counted
`define RESET_SEL_CYCLES  14
`define WAKE_RC_CYCLES    6
`define WAKE_LF_SHORT     1024
`define WAKE_LF_LONG      32768
`define WDT_SHORT_CYCLES  4096
`define WDT_LONG_CYCLES   65536
`define SETTLE_CYCLES     2'h3

`endif

/* File: rtl/clock_startup_pkg.sv */
package clock_startup_pkg;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'h0,
    ST_MS    = 3'h1,
    ST_CK14  = 3'h3,
    ST_RUN   = 3'h2,
    ST_SLEEP = 3'h6,
    ST_WAKE  = 3'h7,
    ST_FAULT = 3'h5
  } startup_state_t;

  typedef struct packed {
    logic       divide_by_eight_fuse;
    logic [1:0] startup_time_fuses;
    logic [3:0] clock_source_select_fuses;
  } fuse_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    startup_state_t st;
    fuse_t          fuse;
    logic [1:0]     settle;
    logic           wdt_prev;
    logic           sel_prev;
    logic [6:0]     rc_trim_value;
    logic [7:0]     rdata;
    logic           run;
    logic           div8;
    logic           cfg_err;
    logic           lf_src;
    logic           rc_src;
    logic           pins_en;
  } top_state_t;

endpackage

/* File: rtl/bit_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } sync_state_t;

  sync_state_t q_r;
  sync_state_t q_nxt;

  // First stage feeds only the second
  genvar g;
  for (g = 0; g < W; g++) begin : g_bit
    always_comb begin
      q_nxt.meta[g] = i_async[g];
      q_nxt.stab[g] = q_r.meta[g];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_r <= '0;
    end else if (i_ce) begin
      q_r <= q_nxt;
    end
  end

  assign o_sync = q_r.stab;

endmodule
`default_nettype wire

/* File: rtl/event_counter.sv */
`timescale 1ns/1ns
`default_nettype none

module event_counter #(
  parameter int W = 17
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_ce,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_load_val,
  input  wire logic         i_tick,
  output logic              o_busy
);

  typedef struct packed {
    logic         busy;
    logic [W-1:0] cnt;
  } cnt_state_t;

  cnt_state_t q_r;
  cnt_state_t q_nxt;

  // Load wins over a tick in the same cycle
  always_comb begin
    q_nxt = q_r;
    if (i_load) begin
      q_nxt.busy = 1'b1;
      q_nxt.cnt  = i_load_val;
    end else if (q_r.busy && i_tick) begin
      q_nxt.cnt = q_r.cnt - 1'b1;
      if (q_r.cnt <= {{(W-1){1'b0}}, 1'b1}) begin
        q_nxt.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q_r <= '0;
    end else if (i_ce) begin
      q_r <= q_nxt;
    end
  end

  assign o_busy = q_r.busy;

endmodule
`default_nettype wire

/* File: rtl/clock_source_startup_select.sv */
// Notes on behaviour
// - Source codes 0110 and 0111 select the 32.768 kHz crystal.
// - Crystal start codes: 00 14 clocks, 01 adds 4.1 ms, 10 65 ms.
// - Crystal wake delay: 1K clocks for 0110, 32K clocks for 0111.
// - Source code 0010 selects the internal 8 MHz RC oscillator.
// - Programmed divide fuse divides RC clock by eight at start-up.
// - Reset copies the factory calibration byte into the trim register.
// - Reset time-out stays timed by the watchdog oscillator.
// - RC wake delay 6 clocks; reset delay as crystal, code 11 reserved.
// - With RC selected the crystal pins serve the timer oscillator.
// - Trim register holds a 7-bit trim value in bits 6 to 0.
// - Trim zero is slowest, larger is faster, 0x7F fastest.
// - Frequency spans 50-100%, 75-150%, 100-200% at 00, 3F, 7F.
// - A fuse reading one is unprogrammed, zero is programmed.
// - Millisecond delays count 4,096 or 65,536 watchdog cycles.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "clock_startup_regs.svh"

module clock_source_startup_select #(
  parameter int WDT_SHORT = `WDT_SHORT_CYCLES,
  parameter int WDT_LONG  = `WDT_LONG_CYCLES,
  parameter int LF_LONG   = `WAKE_LF_LONG
) (
  input  wire logic                     i_mclk,
  input  wire logic                     i_nrst,
  input  wire logic                     i_ce,
  input  wire clock_startup_pkg::fuse_t i_fuses,
  input  wire logic [6:0]               i_cal_byte,
  input  wire logic                     i_wdt_osc,
  input  wire logic                     i_sel_osc,
  input  wire logic                     i_sleep,
  input  wire logic [7:0]               i_addr,
  input  wire logic [7:0]               i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic [7:0]                    o_rdata,
  output logic [6:0]                    o_rc_trim_value,
  output logic                          o_cpu_run,
  output logic                          o_div8_active,
  output logic                          o_lf_xtal_sel,
  output logic                          o_rc_osc_sel,
  output logic                          o_timer_osc_pins_en,
  output logic                          o_cfg_err
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  logic [1:0] rst_pipe_r;
  logic       rst_n;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_pipe_r <= 2'h0;
    end else if (i_ce) begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe_r[1];

  clock_startup_pkg::fuse_t fuse_sync;
  logic                     wdt_sync;
  logic                     sel_sync;
  logic                     sleep_sync;

  // Fuses and oscillators all come from outside this clock domain
  bit_sync #(.W(10)) u_sync (
    .i_clk   (i_mclk),
    .i_rst_n (rst_n),
    .i_ce    (i_ce),
    .i_async ({i_fuses, i_wdt_osc, i_sel_osc, i_sleep}),
    .o_sync  ({fuse_sync, wdt_sync, sel_sync, sleep_sync})
  );

  ////////////////////////////////////////////////////////////////////////
  // Cycle counters

  clock_startup_pkg::top_state_t q_r;
  clock_startup_pkg::top_state_t q_nxt;
  clock_startup_pkg::reg_req_t   req;

  logic        sel_load;
  logic [16:0] sel_val;
  logic        sel_busy;
  logic        wdt_load;
  logic [16:0] wdt_val;
  logic        wdt_busy;
  logic        sel_edge;
  logic        wdt_edge;
  logic        lf_code;
  logic        rc_code;

  assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};
  assign sel_edge = sel_sync & ~q_r.sel_prev;
  assign wdt_edge = wdt_sync & ~q_r.wdt_prev;

  event_counter #(.W(17)) u_sel_cnt (
    .i_clk      (i_mclk),
    .i_rst_n    (rst_n),
    .i_ce       (i_ce),
    .i_load     (sel_load),
    .i_load_val (sel_val),
    .i_tick     (sel_edge),
    .o_busy     (sel_busy)
  );

  // Watchdog oscillator times the millisecond part of the reset delay whatever the source
  event_counter #(.W(17)) u_wdt_cnt (
    .i_clk      (i_mclk),
    .i_rst_n    (rst_n),
    .i_ce       (i_ce),
    .i_load     (wdt_load),
    .i_load_val (wdt_val),
    .i_tick     (wdt_edge),
    .o_busy     (wdt_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and registers

  always_comb begin
    q_nxt          = q_r;
    sel_load       = 1'b0;
    sel_val        = 17'h00000;
    wdt_load       = 1'b0;
    wdt_val        = 17'h00000;
    lf_code        = 1'b0;
    rc_code        = 1'b0;
    q_nxt.sel_prev = sel_sync;
    q_nxt.wdt_prev = wdt_sync;
    q_nxt.rdata    = 8'h00;

    unique case (q_r.st)
      clock_startup_pkg::ST_HOLD: begin
        q_nxt.rc_trim_value = i_cal_byte;
        q_nxt.fuse          = fuse_sync;
        if (q_r.settle != `SETTLE_CYCLES) begin
          q_nxt.settle = q_r.settle + 2'h1;
        end else begin
          lf_code = (fuse_sync.clock_source_select_fuses
                     == `CKSRC_LF_SHORT) ||
                    (fuse_sync.clock_source_select_fuses
                     == `CKSRC_LF_LONG);
          rc_code = fuse_sync.clock_source_select_fuses
                    == `CKSRC_RC;
          if (!(lf_code || rc_code) ||
              fuse_sync.startup_time_fuses == `DELAY_RESERVED) begin
            q_nxt.st      = clock_startup_pkg::ST_FAULT;
            q_nxt.cfg_err = 1'b1;
          end else begin
            q_nxt.lf_src  = lf_code;
            q_nxt.rc_src  = rc_code;
            q_nxt.pins_en = rc_code;
            // Zero means programmed
            q_nxt.div8 = rc_code & ~fuse_sync.divide_by_eight_fuse;
            if (fuse_sync.startup_time_fuses == `DELAY_NONE) begin
              q_nxt.st = clock_startup_pkg::ST_CK14;
              sel_load = 1'b1;
              sel_val  = 17'(`RESET_SEL_CYCLES);
            end else begin
              q_nxt.st = clock_startup_pkg::ST_MS;
              wdt_load = 1'b1;
              wdt_val  = (fuse_sync.startup_time_fuses == `DELAY_SHORT) ?
                         17'(WDT_SHORT) : 17'(WDT_LONG);
            end
          end
        end
      end
      clock_startup_pkg::ST_MS: begin
        if (!wdt_busy) begin
          q_nxt.st = clock_startup_pkg::ST_CK14;
          sel_load = 1'b1;
          sel_val  = 17'(`RESET_SEL_CYCLES);
        end
      end
      clock_startup_pkg::ST_CK14: begin
        if (!sel_busy) begin
          q_nxt.st  = clock_startup_pkg::ST_RUN;
          q_nxt.run = 1'b1;
        end
      end
      clock_startup_pkg::ST_RUN: begin
        if (sleep_sync) begin
          q_nxt.st  = clock_startup_pkg::ST_SLEEP;
          q_nxt.run = 1'b0;
        end
      end
      clock_startup_pkg::ST_SLEEP: begin
        if (!sleep_sync) begin
          q_nxt.st = clock_startup_pkg::ST_WAKE;
          sel_load = 1'b1;
          if (q_r.rc_src) begin
            sel_val = 17'(`WAKE_RC_CYCLES);
          end else if (q_r.fuse.clock_source_select_fuses[0]) begin
            sel_val = 17'(LF_LONG);
          end else begin
            sel_val = 17'(`WAKE_LF_SHORT);
          end
        end
      end
      clock_startup_pkg::ST_WAKE: begin
        if (!sel_busy) begin
          q_nxt.st  = clock_startup_pkg::ST_RUN;
          q_nxt.run = 1'b1;
        end
      end
      clock_startup_pkg::ST_FAULT: begin
        // Reserved settings never start the core
        q_nxt.run = 1'b0;
      end
      default: begin
        q_nxt.st = clock_startup_pkg::ST_FAULT;
      end
    endcase

    // Oscillator frequency rises monotonically with the trim value
    if (req.wr && req.addr == `TRIM_REG_OFS &&
        q_r.st != clock_startup_pkg::ST_HOLD) begin
      q_nxt.rc_trim_value = req.wdata[6:0];
    end

    if (req.rd) begin
      if (req.addr == `TRIM_REG_OFS) begin
        q_nxt.rdata = {1'b0, q_r.rc_trim_value};
      end else if (req.addr == `STATUS_REG_OFS) begin
        q_nxt.rdata[`STAT_STATE_LSB +: 3] = q_r.st;
        q_nxt.rdata[`STAT_RUN_BIT]        = q_r.run;
        q_nxt.rdata[`STAT_DIV8_BIT]       = q_r.div8;
        q_nxt.rdata[`STAT_ERR_BIT]        = q_r.cfg_err;
        q_nxt.rdata[`STAT_LF_BIT]         = q_r.lf_src;
        q_nxt.rdata[`STAT_RC_BIT]         = q_r.rc_src;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      q_r               <= '0;
      q_r.st            <= clock_startup_pkg::ST_HOLD;
      q_r.rc_trim_value <= `TRIM_RESET;
      q_r.div8          <= `DIV8_RESET;
    end else if (i_ce) begin
      q_r <= q_nxt;
    end
  end

  assign o_rdata             = q_r.rdata;
  assign o_rc_trim_value     = q_r.rc_trim_value;
  assign o_cpu_run           = q_r.run;
  assign o_div8_active       = q_r.div8;
  assign o_lf_xtal_sel       = q_r.lf_src;
  assign o_rc_osc_sel        = q_r.rc_src;
  assign o_timer_osc_pins_en = q_r.pins_en;
  assign o_cfg_err           = q_r.cfg_err;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n);

  property p_lf_sel;
    q_r.st == clock_startup_pkg::ST_CK14 && q_r.fuse.clock_source_select_fuses
      inside {`CKSRC_LF_SHORT, `CKSRC_LF_LONG} |->
      o_lf_xtal_sel && !o_rc_osc_sel;
  endproperty
  a_lf_sel: assert property (p_lf_sel) else $error("lf source not set");

  property p_rc_sel;
    q_r.st == clock_startup_pkg::ST_RUN |->
      o_rc_osc_sel == (q_r.fuse.clock_source_select_fuses == `CKSRC_RC);
  endproperty
  a_rc_sel: assert property (p_rc_sel) else $error("rc source mismatch");

  property p_pins;
    q_r.st == clock_startup_pkg::ST_RUN |-> o_timer_osc_pins_en ==
      (q_r.fuse.clock_source_select_fuses == `CKSRC_RC);
  endproperty
  a_pins: assert property (p_pins) else $error("timer pins wrong");

  property p_div8;
    $rose(o_cpu_run) |->
      o_div8_active == (o_rc_osc_sel && !q_r.fuse.divide_by_eight_fuse);
  endproperty
  a_div8: assert property (p_div8) else $error("divide fuse ignored");

  property p_cal;
    i_ce && q_r.st == clock_startup_pkg::ST_HOLD |=>
      o_rc_trim_value == $past(i_cal_byte);
  endproperty
  a_cal: assert property (p_cal) else $error("calibration not loaded");

  property p_run_gate;
    $rose(o_cpu_run) |-> !$past(sel_busy) && !$past(wdt_busy) &&
      $past(q_r.st) inside {clock_startup_pkg::ST_CK14,
                            clock_startup_pkg::ST_WAKE};
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("early run");

  property p_ms_len;
    q_r.st == clock_startup_pkg::ST_MS &&
      $past(q_r.st) == clock_startup_pkg::ST_HOLD |->
      u_wdt_cnt.q_r.cnt == ((q_r.fuse.startup_time_fuses == `DELAY_SHORT) ?
                            17'(WDT_SHORT) : 17'(WDT_LONG));
  endproperty
  a_ms_len: assert property (p_ms_len) else $error("bad reset delay");

  property p_wake_len;
    i_ce && q_r.st == clock_startup_pkg::ST_SLEEP && !sleep_sync |=>
      q_r.st == clock_startup_pkg::ST_WAKE && sel_busy;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("no wake count");

  property p_fault;
    o_cfg_err |-> !o_cpu_run && q_r.st == clock_startup_pkg::ST_FAULT;
  endproperty
  a_fault: assert property (p_fault) else $error("reserved code ran");

  property p_trim_rd;
    i_ce && req.rd && req.addr == `TRIM_REG_OFS |=>
      o_rdata == {1'b0, $past(q_r.rc_trim_value)};
  endproperty
  a_trim_rd: assert property (p_trim_rd) else $error("trim readback");

  c_run:   cover property ($rose(o_cpu_run));
  c_sleep: cover property (q_r.st == clock_startup_pkg::ST_WAKE ##1
                           q_r.st == clock_startup_pkg::ST_RUN);
  c_fault: cover property ($rose(o_cfg_err));
  c_trim:  cover property (req.wr && req.addr == `TRIM_REG_OFS && o_cpu_run);

endmodule
`default_nettype wire

/* File: verif/test_clock_source_startup_select.sv */
`timescale 1ns/1ns
`default_nettype none
`include "clock_startup_regs.svh"

module test_clock_source_startup_select;

  // Short counts keep the run small; expectations follow these values
  localparam int WS = 8;
  localparam int WL = 16;
  localparam int LL = 12;

  localparam logic [6:0] FZ  [6] = '{7'h42, 7'h12, 7'h66, 7'h47, 7'h72, 7'h40};
  localparam logic [6:0] CAL [6] = '{7'h55, 7'h2A, 7'h7F, 7'h00, 7'h3F, 7'h11};
  localparam int         MS  [6] = '{0, WS, WL, 0, 0, 0};
  localparam int         WK  [6] = '{6, 6, 1024, LL, 0, 0};

  logic                     i_mclk    = 1'b0;
  logic                     i_nrst    = 1'b0;
  logic                     i_ce      = 1'b1;
  clock_startup_pkg::fuse_t i_fuses   = clock_startup_pkg::fuse_t'(7'h42);
  logic [6:0]               i_cal_byte = 7'h00;
  logic                     i_wdt_osc = 1'b0;
  logic                     i_sel_osc = 1'b0;
  logic                     i_sleep   = 1'b0;
  logic [7:0]               i_addr    = 8'h00;
  logic [7:0]               i_wdata   = 8'h00;
  logic                     i_wr      = 1'b0;
  logic                     i_rd      = 1'b0;
  logic [7:0]               o_rdata;
  logic [6:0]               o_rc_trim_value;
  logic                     o_cpu_run;
  logic                     o_div8_active;
  logic                     o_lf_xtal_sel;
  logic                     o_rc_osc_sel;
  logic                     o_timer_osc_pins_en;
  logic                     o_cfg_err;
  int                       bad_count   = 0;
  int                       comparisons = 0;

  always #20 i_mclk = ~i_mclk;

  clock_source_startup_select #(
    .WDT_SHORT (WS),
    .WDT_LONG  (WL),
    .LF_LONG   (LL)
  ) i_dut (
    .i_mclk              (i_mclk),
    .i_nrst              (i_nrst),
    .i_ce                (i_ce),
    .i_fuses             (i_fuses),
    .i_cal_byte          (i_cal_byte),
    .i_wdt_osc           (i_wdt_osc),
    .i_sel_osc           (i_sel_osc),
    .i_sleep             (i_sleep),
    .i_addr              (i_addr),
    .i_wdata             (i_wdata),
    .i_wr                (i_wr),
    .i_rd                (i_rd),
    .o_rdata             (o_rdata),
    .o_rc_trim_value     (o_rc_trim_value),
    .o_cpu_run           (o_cpu_run),
    .o_div8_active       (o_div8_active),
    .o_lf_xtal_sel       (o_lf_xtal_sel),
    .o_rc_osc_sel        (o_rc_osc_sel),
    .o_timer_osc_pins_en (o_timer_osc_pins_en),
    .o_cfg_err           (o_cfg_err)
  );

  ////////////////////////////////////////////////////////////////////////////

  task automatic results();
    $display("Counts: %0d comparisons, %0d bad", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
  endtask

  // Read data only stand in the cycle after the strobe, so sample there
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    #1 v = o_rdata;
  endtask

  // Slow edges: eight system cycles apart, wider than the two-stage sync
  task automatic osc_edges(input logic wdt, input int n);
    repeat (n) begin
      @(posedge i_mclk);
      if (wdt) i_wdt_osc <= 1'b1;
      else i_sel_osc <= 1'b1;
      repeat (4) @(posedge i_mclk);
      if (wdt) i_wdt_osc <= 1'b0;
      else i_sel_osc <= 1'b0;
      repeat (3) @(posedge i_mclk);
    end
    #1;
  endtask

  task automatic sel_until_run(input int max, output int n);
    n = 0;
    while (o_cpu_run !== 1'b1 && n < max) begin
      osc_edges(1'b0, 1);
      n++;
    end
    if (o_cpu_run !== 1'b1) begin
      bad_count++;
      $display("Error at %0t: execution never released", $time);
      results();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////

  task automatic run_case(input int k);
    logic [7:0] v;
    int         n;
    logic [3:0] cs;
    logic       rc;
    logic       lf;
    cs = FZ[k][3:0];
    rc = (cs == `CKSRC_RC);
    lf = (cs == `CKSRC_LF_SHORT) || (cs == `CKSRC_LF_LONG);
    @(posedge i_mclk);
    i_nrst     <= 1'b0;
    i_sleep    <= 1'b0;
    i_fuses    <= clock_startup_pkg::fuse_t'(FZ[k]);
    i_cal_byte <= CAL[k];
    repeat (8) @(posedge i_mclk);
    #1;
    chk(16'(o_rc_trim_value), 16'h0000);
    chk(16'(o_cpu_run), 16'h0000);
    chk(16'(o_div8_active), 16'h0001);
    chk(16'(o_cfg_err), 16'h0000);
    chk(16'(o_rdata), 16'h0000);
    @(posedge i_mclk);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    // Lands while the calibration load is still in progress and is dropped
    reg_wr(`TRIM_REG_OFS, 8'h01);
    repeat (8) @(posedge i_mclk);
    reg_rd(`TRIM_REG_OFS, v);
    chk(16'(v), 16'({1'b0, CAL[k]}));
    if (k >= 4) begin
      chk(16'(o_cfg_err), 16'h0001);
      osc_edges(1'b0, 20);
      chk(16'(o_cpu_run), 16'h0000);
    end else begin
      chk(16'(o_lf_xtal_sel), 16'(lf));
      chk(16'(o_rc_osc_sel), 16'(rc));
      chk(16'(o_timer_osc_pins_en), 16'(rc));
      chk(16'(o_div8_active), 16'(rc & ~FZ[k][6]));
      if (MS[k] > 0) begin
        osc_edges(1'b1, MS[k] - 1);
        osc_edges(1'b0, 20);
        chk(16'(o_cpu_run), 16'h0000);
        osc_edges(1'b1, 1);
      end
      sel_until_run(20, n);
      chk(16'(n), 16'h000E);
      if (k == 0) begin
        // No memory write runs beside this, so a full trim is allowed
        reg_wr(`TRIM_REG_OFS, 8'hFF);
        reg_rd(`TRIM_REG_OFS, v);
        chk(16'(v), 16'h007F);
        chk(16'(o_rc_trim_value), 16'h007F);
        @(posedge i_mclk);
        #1 chk(16'(o_rdata), 16'h0000);
        reg_wr(`STATUS_REG_OFS, 8'h00);
        reg_rd(`STATUS_REG_OFS, v);
        chk(16'(v), 16'({4'h8, 1'b1, clock_startup_pkg::ST_RUN}));
        reg_rd(8'hEE, v);
        chk(16'(v), 16'h0000);
        reg_wr(`TRIM_REG_OFS, 8'h00);
        reg_rd(`TRIM_REG_OFS, v);
        chk(16'(v), 16'h0000);
        // A low enable freezes state, so this write must not land
        @(posedge i_mclk);
        i_ce <= 1'b0;
        reg_wr(`TRIM_REG_OFS, 8'h2A);
        @(posedge i_mclk);
        i_ce <= 1'b1;
        #1 chk(16'(o_rc_trim_value), 16'h0000);
      end
      @(posedge i_mclk);
      i_sleep <= 1'b1;
      repeat (8) @(posedge i_mclk);
      #1 chk(16'(o_cpu_run), 16'h0000);
      @(posedge i_mclk);
      i_sleep <= 1'b0;
      repeat (4) @(posedge i_mclk);
      #1;
      sel_until_run(WK[k] + 4, n);
      chk(16'(n), 16'(WK[k]));
    end
    $display("Test %0d done, %0d mismatches so far", k, bad_count);
  endtask

  initial begin
    repeat (8) @(posedge i_mclk);
    for (int k = 0; k < 6; k++) begin
      run_case(k);
    end
    results();
  end

endmodule

`default_nettype wire
